// >>> shared/eas_pkg.sv
package eas_pkg;

  // Chosen command codes; any other code is ignored for the rest of the frame
  localparam logic [7:0] OP_BANK_WR   = 8'h17;
  localparam logic [7:0] OP_LEGACY_RD = 8'h03;
  localparam logic [7:0] OP_NEW_RD    = 8'h13;
  localparam logic [7:0] OP_OTHER_RD  = 8'h4B;

  localparam int unsigned CMD_BITS      = 8;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned ADDR_LEGACY_W = 24;
  localparam int unsigned BANK_EXT_BIT  = 7;
  localparam int unsigned SYNC_STAGES   = 2;

  localparam logic [5:0] CMD_LAST   = 6'h07;
  localparam logic [5:0] BANK_LAST  = 6'h07;
  localparam logic [5:0] ADDR24_LAST = 6'h17;
  localparam logic [5:0] ADDR32_LAST = 6'h1F;
  localparam logic [7:0] BANK_RESET = 8'h00;

  typedef enum logic [2:0] {
    EAS_IDLE   = 3'b000,
    EAS_CMD    = 3'b001,
    EAS_ADDR   = 3'b010,
    EAS_BANK   = 3'b011,
    EAS_IGNORE = 3'b100
  } eas_state_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } eas_spi_in_t;

  typedef struct packed {
    eas_state_t  st;
    logic [5:0]  cnt;
    logic [31:0] shreg;
    logic [7:0]  cmd;
    logic [7:0]  bank;
    logic        len32;
    logic        main_space;
    logic [31:0] addr;
    logic        valid;
    logic        sck_prev;
  } eas_regs_t;

  localparam eas_regs_t REGS_RESET = '{
    st:         EAS_IDLE,
    cnt:        6'h00,
    shreg:      32'h0000_0000,
    cmd:        8'h00,
    bank:       BANK_RESET,
    len32:      1'b0,
    main_space: 1'b0,
    addr:       32'h0000_0000,
    valid:      1'b0,
    // Synchroniser resets high; matching it avoids a false clock edge
    sck_prev:   1'b1
  };

endpackage : eas_pkg

// >>> tb/eas_host.sv
`timescale 1ns/1ps
`default_nettype none

module eas_host (
  input  wire logic sys_clk_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // Half of the 80 ns link period, launched just after a system edge
  task half;
    repeat (5) @(posedge sys_clk_i);
    #1;
  endtask : half

  // Command byte, then the low n bits of d, MSB first; n below the 8, 24 or 32 bits the command needs aborts
  task frame(input logic [7:0] op, input logic [31:0] d, input int n);
    logic [39:0] w;
    w = {op, d << (32 - n)};
    @(posedge sys_clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < 8 + n; i++)
    begin
      sck_o = 1'b0;
      si_o  = w[39-i];
      half;
      sck_o = 1'b1;
      half;
    end
    sck_o = 1'b0;
    si_o  = ~si_o;
    half;
    cs_n_o = 1'b1;
    half;
  endtask : frame
endmodule : eas_host

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  wire logic   sck;
  wire logic   cs_n;
  wire logic   si;
  logic [31:0] addr;
  logic [31:0] addr_s;
  logic [31:0] got_a[$];
  logic [31:0] got_s[$];
  logic        valid;
  logic        len32;
  logic        main_sp;
  logic        ext;
  logic [7:0]  cmd;
  logic [7:0]  bank;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          seed        = 93;
  int          mbank       = 0;

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
    if (valid === 1'b1)
    begin
      got_a.push_back(addr);
      got_s.push_back(addr_s);
    end

  eas_top u_eas_top (
    .sys_clk_i(sys_clk), .rst_i(rst), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_si_i(si), .addr_o(addr), .addr_valid_o(valid), .addr_len32_o(len32),
    .main_space_o(main_sp), .cmd_o(cmd), .bank_o(bank), .ext_mode_o(ext)
  );

  // Small-density copy fed by the same wires
  eas_top #(.SMALL_DENSITY(1'b1)) u_eas_top_small (
    .sys_clk_i(sys_clk), .rst_i(rst), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_si_i(si), .addr_o(addr_s), .addr_valid_o(), .addr_len32_o(),
    .main_space_o(), .cmd_o(), .bank_o(), .ext_mode_o()
  );

  eas_host u_eas_host (.sys_clk_i(sys_clk), .sck_o(sck), .cs_n_o(cs_n),
                       .si_o(si));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] ea(logic [7:0] op, logic [31:0] a, bit sm);
    logic [31:0] r;
    r = a;
    if (op == eas_pkg::OP_LEGACY_RD && mbank[7] == 1'b0)
      r = {1'b0, 7'(mbank), a[23:0]};
    if (sm && op != eas_pkg::OP_OTHER_RD)
      r[31:24] = 8'h00;
    return r;
  endfunction : ea

  task run(input logic [7:0] op, input logic [31:0] a, input int n,
           input int ok);
    got_a.delete();
    got_s.delete();
    u_eas_host.frame(op, a, n);
    repeat (8) @(posedge sys_clk);
    chk(32'(got_a.size()), 32'(ok));
  endtask : run

  task rd(input logic [7:0] op, input int n);
    logic [31:0] a;
    a = $random(seed);
    run(op, a, n, 1);
    chk(got_a[0], ea(op, a, 1'b0));
    chk(got_s[0], ea(op, a, 1'b1));
    chk(32'({len32, main_sp, cmd}),
        32'({n == 32, op != eas_pkg::OP_OTHER_RD, op}));
  endtask : rd

  task bw(input logic [7:0] b);
    run(eas_pkg::OP_BANK_WR, 32'(b), 8, 0);
    mbank = b;
    chk(32'({bank, ext}), 32'({b, b[7]}));
  endtask : bw

  task do_reset;
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    mbank = 0;
    repeat (6) @(posedge sys_clk);
    chk(32'({bank, ext, valid}), 32'h0000_0000);
  endtask : do_reset

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  initial
  begin
    do_reset;
    rd(eas_pkg::OP_LEGACY_RD, 24);
    for (int k = 0; k < 3; k++)
    begin
      bw(8'($random(seed)) & 8'h7F);
      rd(eas_pkg::OP_LEGACY_RD, 24);
    end
    rd(eas_pkg::OP_NEW_RD, 32);
    rd(eas_pkg::OP_OTHER_RD, 32);
    $display("test 24-bit mode done");
    bw(8'($random(seed)) | 8'h80);
    rd(eas_pkg::OP_LEGACY_RD, 32);
    rd(eas_pkg::OP_NEW_RD, 32);
    rd(eas_pkg::OP_OTHER_RD, 32);
    $display("test 32-bit mode done");
    run(8'h5A, $random(seed), 32, 0);
    run(eas_pkg::OP_LEGACY_RD, $random(seed), 12, 0);
    $display("test refusals done");
    do_reset;
    rd(eas_pkg::OP_LEGACY_RD, 24);
    $display("test second reset done");
    test_done;
  end

  initial
  begin
    #400_000;
    n_fail++;
    test_done;
  end
endmodule : tb_top

`default_nettype wire

// >>> verilog/eas_sync.sv
`timescale 1ns/1ps
`default_nettype none

module eas_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  // Two flops per bit; first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_comb
    begin
      meta_next[i] = d_i[i];
      q_next[i]    = meta_reg[i];
    end

    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
      begin
        meta_reg[i] <= 1'b1;
        q_o[i]      <= 1'b1;
      end
      else
      begin
        meta_reg[i] <= meta_next[i];
        q_o[i]      <= q_next[i];
      end
    end
  end

endmodule : eas_sync

`default_nettype wire

// >>> verilog/eas_top.sv
// Behaviour
// R01: Accept byte addresses up to 32 bits.
// R02: Legacy commands keep 24-bit addressing.
// R03: Bank register supplies upper bits, host loaded.
// R04: Extended mode makes legacy commands take 32.
// R05: New commands always take 32 address bits.
// R06: Reset clears bank register, selects 24-bit.
// R07: Small variant ignores bits 31..24 on array.
// R08: Other spaces take full 32-bit address.
// R09: 24-bit mode places bank bits above address.
`timescale 1ns/1ps
`default_nettype none

module eas_top #(
  parameter bit SMALL_DENSITY = 1'b0
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_si_i,
  output logic      [31:0] addr_o,
  output logic             addr_valid_o,
  output logic             addr_len32_o,
  output logic             main_space_o,
  output logic      [7:0]  cmd_o,
  output logic      [7:0]  bank_o,
  output logic             ext_mode_o
);

  eas_pkg::eas_regs_t   s_reg;
  eas_pkg::eas_regs_t   s_next;
  eas_pkg::eas_spi_in_t pins;
  logic [2:0]           pins_raw;
  logic                 sck_rise;
  logic [31:0]          sh_in;
  logic                 bank_load;

  eas_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       ({spi_sck_i, spi_cs_n_i, spi_si_i}),
    .q_o       (pins_raw)
  );

  assign pins = eas_pkg::eas_spi_in_t'(pins_raw);

  // Effective address from the received bits
  function automatic logic [31:0] form_addr(
    input logic [31:0] raw,
    input logic        len32,
    input logic        main_space,
    input logic [7:0]  bank
  );
    logic [31:0] a;
    a = raw;
    if (!len32)
    begin
      a = {1'b0, bank[6:0], raw[23:0]}; // R09 R03 R02
    end
    if (SMALL_DENSITY && main_space)
    begin
      a[31:24] = 8'h00; // R07
    end
    return a;
  endfunction : form_addr

  always_comb
  begin
    s_next          = s_reg;
    s_next.valid    = 1'b0;
    s_next.sck_prev = pins.sck;
    sck_rise        = pins.sck & ~s_reg.sck_prev;
    sh_in           = {s_reg.shreg[30:0], pins.si};
    bank_load       = 1'b0;
    if (pins.cs_n)
    begin
      s_next.st  = eas_pkg::EAS_IDLE;
      s_next.cnt = 6'h00;
    end
    else
    begin
      case (s_reg.st)
        eas_pkg::EAS_IDLE:
        begin
          s_next.st  = eas_pkg::EAS_CMD;
          s_next.cnt = 6'h00;
        end
        eas_pkg::EAS_CMD:
        begin
          if (sck_rise)
          begin
            s_next.shreg = sh_in;
            s_next.cnt   = s_reg.cnt + 6'h01;
            if (s_reg.cnt == eas_pkg::CMD_LAST)
            begin
              s_next.cmd = sh_in[7:0];
              s_next.cnt = 6'h00;
              s_next.st  = eas_pkg::EAS_ADDR;
              if (sh_in[7:0] == eas_pkg::OP_BANK_WR)
              begin
                s_next.st = eas_pkg::EAS_BANK;
              end
              else if (sh_in[7:0] == eas_pkg::OP_LEGACY_RD)
              begin
                s_next.len32      = s_reg.bank[eas_pkg::BANK_EXT_BIT]; // R04 R02
                s_next.main_space = 1'b1;
              end
              else if (sh_in[7:0] == eas_pkg::OP_NEW_RD)
              begin
                s_next.len32      = 1'b1; // R05
                s_next.main_space = 1'b1;
              end
              else if (sh_in[7:0] == eas_pkg::OP_OTHER_RD)
              begin
                s_next.len32      = 1'b1; // R08
                s_next.main_space = 1'b0;
              end
              else
              begin
                s_next.st = eas_pkg::EAS_IGNORE;
              end
            end
          end
        end
        eas_pkg::EAS_ADDR:
        begin
          if (sck_rise)
          begin
            s_next.shreg = sh_in;
            s_next.cnt   = s_reg.cnt + 6'h01;
            if ((s_reg.len32 && s_reg.cnt == eas_pkg::ADDR32_LAST) ||
                (!s_reg.len32 && s_reg.cnt == eas_pkg::ADDR24_LAST))
            begin
              s_next.addr  = form_addr(sh_in, s_reg.len32,
                                       s_reg.main_space, s_reg.bank); // R01
              s_next.valid = 1'b1;
              s_next.st    = eas_pkg::EAS_IGNORE;
            end
          end
        end
        eas_pkg::EAS_BANK:
        begin
          if (sck_rise)
          begin
            s_next.shreg = sh_in;
            s_next.cnt   = s_reg.cnt + 6'h01;
            if (s_reg.cnt == eas_pkg::BANK_LAST)
            begin
              s_next.bank = sh_in[7:0]; // R03
              bank_load   = 1'b1;
              s_next.st   = eas_pkg::EAS_IGNORE;
            end
          end
        end
        default:
        begin
          s_next.st = eas_pkg::EAS_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= eas_pkg::REGS_RESET; // R06
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign addr_o       = s_reg.addr;
  assign addr_valid_o = s_reg.valid;
  assign addr_len32_o = s_reg.len32;
  assign main_space_o = s_reg.main_space;
  assign cmd_o        = s_reg.cmd;
  assign bank_o       = s_reg.bank;
  assign ext_mode_o   = s_reg.bank[eas_pkg::BANK_EXT_BIT];

  a_reset_bank_clear: assert property ( // R06
    @(posedge sys_clk_i) rst_i |=>
      (bank_o == 8'h00 && !ext_mode_o && !addr_valid_o))
    else $error("bank register not cleared by reset");

  a_bank_load_value: assert property ( // R03
    @(posedge sys_clk_i) disable iff (rst_i)
    bank_load |=> (bank_o == $past(sh_in[7:0])))
    else $error("bank register did not load received byte");

  a_legacy_len_mode: assert property ( // R04
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_valid_o && cmd_o == eas_pkg::OP_LEGACY_RD)
      |-> (addr_len32_o == ext_mode_o))
    else $error("legacy address length does not follow mode");

  a_new_len_full: assert property ( // R05
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_valid_o && cmd_o == eas_pkg::OP_NEW_RD) |-> addr_len32_o)
    else $error("new command did not take 32 address bits");

  a_other_len_full: assert property ( // R08
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_valid_o && cmd_o == eas_pkg::OP_OTHER_RD)
      |-> (addr_len32_o && !main_space_o))
    else $error("other space command not 32-bit");

  a_bank_above_addr: assert property ( // R09
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_valid_o && !addr_len32_o && !SMALL_DENSITY)
      |-> (addr_o[31:24] == {1'b0, bank_o[6:0]}))
    else $error("bank bits not placed above 24-bit address");

  a_small_truncate: assert property ( // R07
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_valid_o && SMALL_DENSITY && main_space_o)
      |-> (addr_o[31:24] == 8'h00))
    else $error("small variant kept upper address bits");

  a_full_addr_kept: assert property ( // R01
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_valid_o && addr_len32_o && !(SMALL_DENSITY && main_space_o))
      |-> (addr_o == s_reg.shreg))
    else $error("32-bit address altered");

  a_valid_one_cycle: assert property ( // R02
    @(posedge sys_clk_i) disable iff (rst_i)
    addr_valid_o |=> !addr_valid_o)
    else $error("address valid longer than one cycle");

endmodule : eas_top

`default_nettype wire
